// ---- ebc_top.sv ----
// External bus chip-select interface with burst flash link.
`timescale 1ns/100ps
`default_nettype none
`include "ebc_consts.svh"
module ebc_top #(
  parameter int WAIT_STATES = `EBC_WAIT_STATES,
  parameter int ACK_TIMEOUT = `EBC_ACK_TIMEOUT,
  parameter int FIRST_LAT   = `EBC_FIRST_LAT
) (
  // Clocks and reset.
  input  wire logic             mclk,
  input  wire logic             link_clk,
  input  wire logic             rst,
  // Internal request and response.
  input  wire logic             req_valid,
  input  wire ebc_pkg::ebc_req_s req,
  output logic                  req_ready,
  output logic                  rsp_valid,
  output ebc_pkg::ebc_rsp_s     rsp,
  // Static configuration and SDRAM selects.
  input  wire logic             function_mux_control,
  input  wire logic [1:0]       sdram_select_n,
  input  wire logic             big_endian_strap,
  // External bus pins.
  output logic [24:0]           addr,
  output logic [31:0]           data_out,
  output logic [31:0]           data_oe,
  input  wire logic [31:0]      data_in,
  output logic                  byte_strobe_msb_n,
  output logic                  byte_strobe_hi_n,
  output logic                  byte_strobe_lo_n,
  output logic                  byte_strobe_lsb_n,
  output logic                  out_en_n,
  output logic                  rd_wr,
  output logic [5:0]            cs_n,
  input  wire logic             data_ack_in_n,
  // Burst flash link.
  input  wire logic             burst_restart_n,
  output logic                  burst_clk,
  output logic                  burst_addr_latch_n
);

  function automatic logic [31:0] swap32(input logic [31:0] x);
    swap32 = {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction

  function automatic logic [3:0] rev4(input logic [3:0] x);
    rev4 = {x[0], x[1], x[2], x[3]};
  endfunction

  //////////////////////////////////////////////////////////////////////////
  ebc_pkg::ebc_st_e  st_r, st_nxt;
  ebc_pkg::ebc_req_s cur_r;
  ebc_pkg::ebc_rsp_s rsp_r;
  logic [9:0]  cnt_r;
  logic [24:0] addr_r;
  logic [31:0] dout_r, doe_r;
  logic [3:0]  strb_r;
  logic        oe_n_r, rw_r, ready_r, rsp_valid_r;
  logic [5:0]  cs_own_r, cs_pin_r;
  logic [2:0]  ack_s, strap_s;
  logic        endian_r, caught_r;
  logic        breq_tgl_r;
  logic [2:0]  bdone_s;
  logic        ldone_tgl_r, ack_armed_r;
  logic [1:0]  fill_r;

  // Sampled pins: three flops, a change counts once the last two agree.
  wire ack_idle   = ack_s[1] & ack_s[2];
  wire ack_seen   = ack_armed_r & ~ack_s[1] & ~ack_s[2];
  wire strap_ok   = (fill_r == 2'h3) & (strap_s[1] == strap_s[2]);
  wire take       = req_valid & ready_r & (st_r == ebc_pkg::ST_IDLE);
  wire bdone      = bdone_s[1] ^ bdone_s[2];
  wire tmo_hit    = cnt_r == 10'(ACK_TIMEOUT - 1);
  wire ws_hit     = cnt_r == 10'(WAIT_STATES - 1);
  wire async_end  = cur_r.use_ack ? (ack_seen | tmo_hit) : ws_hit;
  wire async_err  = cur_r.use_ack & ~ack_seen & tmo_hit;
  wire done_async = (st_r == ebc_pkg::ST_ASYNC) & async_end;
  wire done_burst = (st_r == ebc_pkg::ST_BURST) & bdone;
  wire finish     = done_async | done_burst;
  // Big endian puts the lowest byte address on the most significant lane.
  wire [3:0]  lane_be = endian_r ? rev4(req.be) : req.be;
  wire [31:0] lane_wd = endian_r ? swap32(req.wdata) : req.wdata;
  wire [31:0] link_data;
  wire [31:0] rd_raw  = done_burst ? link_data : data_in;
  wire [31:0] rd_lane = endian_r ? swap32(rd_raw) : rd_raw;
  wire [5:0]  cs_dec  = ~(6'h01 << req.cs);
  wire [5:0]  cs_pin_nxt = function_mux_control ? cs_own_r :
    {cs_own_r[5:4], sdram_select_n, cs_own_r[1:0]};

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ebc_pkg::ST_IDLE: begin
        if (take)
          st_nxt = req.burst ? ebc_pkg::ST_BURST : ebc_pkg::ST_ASYNC;
      end
      ebc_pkg::ST_ASYNC,
      ebc_pkg::ST_BURST: begin
        if (finish)
          st_nxt = ebc_pkg::ST_IDLE;
      end
      default: st_nxt = ebc_pkg::ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_s   <= 3'h7;
      strap_s <= 3'h0;
      bdone_s <= 3'h0;
    end else begin
      ack_s   <= {ack_s[1:0], data_ack_in_n};
      strap_s <= {strap_s[1:0], big_endian_strap};
      bdone_s <= {bdone_s[1:0], ldone_tgl_r};
    end
  end

  // The chain holds its reset value at first; wait until the pin fills it.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      fill_r <= 2'h0;
    else if (fill_r != 2'h3)
      fill_r <= fill_r + 2'h1;
  end

  // An acknowledge still low from the last access must not end this one.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      ack_armed_r <= 1'b0;
    else if (take)
      ack_armed_r <= 1'b0;
    else if (ack_idle)
      ack_armed_r <= 1'b1;
  end

  // The strap is caught once after reset release and never again.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      endian_r <= 1'b0;
      caught_r <= 1'b0;
    end else if (!caught_r && strap_ok) begin
      endian_r <= strap_s[2];
      caught_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r    <= ebc_pkg::ST_IDLE;
      ready_r <= 1'b0;
      cnt_r   <= 10'h000;
      cur_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      ready_r <= caught_r & (st_nxt == ebc_pkg::ST_IDLE) & ~take;
      cnt_r   <= (st_r == ebc_pkg::ST_ASYNC) ? cnt_r + 10'h001 : 10'h000;
      if (take)
        cur_r <= req;
    end
  end

  // Bus pins load on the taking edge and the selects one clock later; all hold until the access ends.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r   <= 25'h0000000;
      dout_r   <= 32'h00000000;
      doe_r    <= 32'h00000000;
      strb_r   <= `EBC_STRB_IDLE;
      oe_n_r   <= 1'b1;
      rw_r     <= 1'b1;
      cs_own_r <= `EBC_CS_IDLE;
      cs_pin_r <= `EBC_CS_IDLE;
    end else begin
      cs_pin_r <= cs_pin_nxt;
      if (take) begin
        addr_r   <= req.addr;
        dout_r   <= lane_wd;
        doe_r    <= {32{req.write}};
        strb_r   <= ~lane_be;
        oe_n_r   <= req.write;
        rw_r     <= ~req.write;
        cs_own_r <= cs_dec;
      end else if (finish) begin
        doe_r    <= 32'h00000000;
        strb_r   <= `EBC_STRB_IDLE;
        oe_n_r   <= 1'b1;
        rw_r     <= 1'b1;
        cs_own_r <= `EBC_CS_IDLE;
      end
    end
  end

  // Read data is taken only after the synchronised acknowledge, the wait-state
  // count, the time-out or the link handshake, so the wide bus has long been stable.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
      breq_tgl_r  <= 1'b0;
    end else begin
      rsp_valid_r <= finish;
      if (finish) begin
        rsp_r.err   <= done_async & async_err;
        rsp_r.rdata <= rd_lane;
      end
      if (take && req.burst)
        breq_tgl_r <= ~breq_tgl_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  ebc_pkg::ebc_lst_e lst_r;
  logic [2:0]  lreq_s;
  logic [7:0]  lcnt_r;
  logic [31:0] ldata_r;
  logic        bclk_r, lat_n_r;
  wire         lstart = lreq_s[1] ^ lreq_s[2];

  assign link_data = ldata_r;

  // The flash answers in step with the burst clock, so its restart line
  // is already in this domain.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      lreq_s      <= 3'h0;
      lst_r       <= ebc_pkg::LS_IDLE;
      lcnt_r      <= 8'h00;
      ldata_r     <= 32'h00000000;
      ldone_tgl_r <= 1'b0;
      bclk_r      <= 1'b0;
      lat_n_r     <= 1'b1;
    end else begin
      lreq_s  <= {lreq_s[1:0], breq_tgl_r};
      bclk_r  <= (lst_r != ebc_pkg::LS_IDLE) & ~bclk_r;
      lat_n_r <= 1'b1;
      case (lst_r)
        ebc_pkg::LS_IDLE: begin
          if (lstart) begin
            lst_r   <= ebc_pkg::LS_LATCH;
            lat_n_r <= 1'b0;
          end
        end
        ebc_pkg::LS_LATCH: begin
          lst_r  <= ebc_pkg::LS_WAIT;
          lcnt_r <= 8'h00;
        end
        ebc_pkg::LS_WAIT: begin
          lcnt_r <= lcnt_r + 8'h01;
          if (!burst_restart_n) begin
            lst_r   <= ebc_pkg::LS_LATCH;
            lat_n_r <= 1'b0;
          end else if (lcnt_r == 8'(FIRST_LAT - 1)) begin
            ldata_r     <= data_in;
            ldone_tgl_r <= ~ldone_tgl_r;
            lst_r       <= ebc_pkg::LS_IDLE;
          end
        end
        default: lst_r <= ebc_pkg::LS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign req_ready          = ready_r;
  assign rsp_valid          = rsp_valid_r;
  assign rsp                = rsp_r;
  assign addr               = addr_r;
  assign data_out           = dout_r;
  assign data_oe            = doe_r;
  assign byte_strobe_msb_n  = strb_r[3];
  assign byte_strobe_hi_n   = strb_r[2];
  assign byte_strobe_lo_n   = strb_r[1];
  assign byte_strobe_lsb_n  = strb_r[0];
  assign out_en_n           = oe_n_r;
  assign rd_wr              = rw_r;
  assign cs_n               = cs_pin_r;
  assign burst_clk          = bclk_r;
  assign burst_addr_latch_n = lat_n_r;

  //////////////////////////////////////////////////////////////////////////
  strobe_lane_a : assert property (
    @(posedge mclk) disable iff (rst)
    take |=> strb_r == ~(endian_r ? rev4($past(req.be)) : $past(req.be)))
    else $error("byte strobes on wrong lanes");
  oe_read_a : assert property (@(posedge mclk) disable iff (rst)
    !oe_n_r |-> rw_r && doe_r == 32'h00000000)
    else $error("output enable outside a read");
  rw_write_a : assert property (@(posedge mclk) disable iff (rst)
    take && req.write |=> !rw_r && oe_n_r)
    else $error("write not driven low on read/write");
  ack_timeout_a : assert property (
    @(posedge mclk) disable iff (rst)
    st_r == ebc_pkg::ST_ASYNC && cur_r.use_ack && tmo_hit && !ack_seen
    |=> rsp_valid_r && rsp_r.err && st_r == ebc_pkg::ST_IDLE)
    else $error("time-out did not end access with error");
  err_cause_a : assert property (@(posedge mclk) disable iff (rst)
    rsp_valid_r && rsp_r.err |-> $past(cnt_r) == 10'(ACK_TIMEOUT - 1))
    else $error("error response without full time-out");
  sdram_route_a : assert property (
    @(posedge mclk) disable iff (rst)
    !function_mux_control |=> cs_n[3:2] == $past(sdram_select_n))
    else $error("sdram selects not routed");
  endian_hold_a : assert property (
    @(posedge mclk) disable iff (rst)
    caught_r |=> $stable(endian_r) && caught_r)
    else $error("endianness changed after capture");
  latch_pulse_a : assert property (
    @(posedge link_clk) disable iff (rst)
    lst_r == ebc_pkg::LS_IDLE && lstart |=> !lat_n_r ##1 lat_n_r)
    else $error("address latch pulse malformed");
  restart_a : assert property (
    @(posedge link_clk) disable iff (rst)
    lst_r == ebc_pkg::LS_WAIT && !burst_restart_n
    |=> lst_r == ebc_pkg::LS_LATCH && !lat_n_r ##1 lcnt_r == 8'h00)
    else $error("restart did not begin new burst");
  bclk_run_a : assert property (
    @(posedge link_clk) disable iff (rst)
    lst_r != ebc_pkg::LS_IDLE && !bclk_r |=> bclk_r)
    else $error("burst clock not running in burst");
  async_done_c : cover property (@(posedge mclk) disable iff (rst)
    done_async && !async_err);
  timeout_c : cover property (@(posedge mclk) disable iff (rst)
    done_async && async_err);
  burst_done_c : cover property (@(posedge mclk) disable iff (rst) done_burst);
  restart_c : cover property (@(posedge link_clk) disable iff (rst)
    lst_r == ebc_pkg::LS_WAIT && !burst_restart_n);

endmodule
`default_nettype wire

// ---- ebc_consts.svh ----
// Constants of the external bus chip-select interface.
//
// Contract
// - Four low byte strobes; first gates D[31:24], last gates D[7:0].
// - Low output enable lets external parts drive the data bus on reads.
// - Read/write line high for reads, low for writes.
// - Acknowledge ends each cycle; none within 1022 clocks is a bus error. Code: single use_ack only; others end after WAIT_STATES clocks, bursts by the link.
// - Selects 3 and 2 shared with SDRAM selects; SDRAM ones after reset. Code: no reset default; function_mux_control picks, SDRAM when low.
// - Restart abandons the burst; a new long-first-access burst begins.
// - Low address-latch pulse at burst start; flash captures the address.
// - Burst clock driven to synchronous memories while in burst mode.
// - Endian strap sampled at reset; high big, low little; held afterwards.
`ifndef EBC_CONSTS_SVH
`define EBC_CONSTS_SVH
`define EBC_ACK_TIMEOUT 1022
`define EBC_WAIT_STATES 2
`define EBC_FIRST_LAT   4
`define EBC_CS_IDLE     6'h3f
`define EBC_STRB_IDLE   4'hf
`define EBC_CS_SDRAM_LO 2
`endif

// ---- ebc_pkg.sv ----
// Types of the external bus chip-select interface.
package ebc_pkg;
  typedef struct packed {
    logic [24:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        write;
    logic [2:0]  cs;
    logic        use_ack;
    logic        burst;
  } ebc_req_s;
  typedef struct packed {
    logic        err;
    logic [31:0] rdata;
  } ebc_rsp_s;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ASYNC = 2'b01,
    ST_BURST = 2'b10
  } ebc_st_e;
  typedef enum logic [1:0] {
    LS_IDLE  = 2'b00,
    LS_LATCH = 2'b01,
    LS_WAIT  = 2'b10
  } ebc_lst_e;
endpackage

// ---- ebc_mem_model.sv ----
// Memory and burst flash model on the far side of the external bus.
`timescale 1ns/100ps
`default_nettype none
module ebc_mem_model (
  // Clocks.
  input  wire logic        mclk,
  input  wire logic        link_clk,
  // Bus pins.
  input  wire logic [5:0]  cs_n,
  input  wire logic        out_en_n,
  input  wire logic        burst_addr_latch_n,
  output logic [31:0]      data_in,
  output logic             data_ack_in_n,
  output logic             burst_restart_n,
  // Scenario controls.
  input  wire logic [31:0] rd_word,
  input  wire logic        ack_on,
  input  wire logic        restart_on
);
  int   ack_cnt = 0;
  int   lk_cnt  = 99;
  logic rs_done = 1'b0;
  initial begin
    data_in = 32'h0;
    data_ack_in_n = 1'b1;
    burst_restart_n = 1'b1;
  end
  // A released data bus shows a changing pattern, not the last word.
  always @(negedge mclk) begin
    data_in <= (!out_en_n || lk_cnt < 9) ? rd_word : ~data_in;
    if (ack_on && cs_n != 6'h3f) begin
      ack_cnt <= ack_cnt + 1;
      data_ack_in_n <= (ack_cnt < 3);
    end else begin
      ack_cnt <= 0;
      data_ack_in_n <= 1'b1;
    end
  end
  // The latch pulse marks the start address; a restart may end the burst.
  always @(negedge link_clk) begin
    if (!burst_addr_latch_n)
      lk_cnt <= 0;
    else if (lk_cnt < 99)
      lk_cnt <= lk_cnt + 1;
    burst_restart_n <= !(restart_on && !rs_done && lk_cnt == 2);
    rs_done <= restart_on && (rs_done || lk_cnt == 2);
  end
endmodule
`default_nettype wire

// ---- ebc_top_tb.sv ----
// Self-checking bench of the external bus chip-select interface.
`timescale 1ns/100ps
`default_nettype none
module ebc_top_tb;
  logic mclk, link_clk, rst, req_valid, req_ready, rsp_valid, fmc, strap;
  logic ack_on, rs_on, dack_n, brst_n, bclk, lat_n, oe_n, rd_wr;
  logic s_msb, s_hi, s_lo, s_lsb;
  logic [1:0] sd_n;
  logic [5:0] cs_n;
  logic [24:0] addr;
  logic [31:0] dout, doe, din, rword;
  logic [33:0] e;
  logic [33:0] expq[$];
  ebc_pkg::ebc_req_s req;
  ebc_pkg::ebc_rsp_s rsp;
  int miscompares = 0, total_checks = 0, cyc = 0, lats = 0, bclks = 0;
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  initial begin
    link_clk = 1'b0;
    #33;
    forever #80 link_clk = ~link_clk;
  end
  ebc_top #(.ACK_TIMEOUT(20)) dut_u (.mclk(mclk), .link_clk(link_clk),
    .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .function_mux_control(fmc),
    .sdram_select_n(sd_n), .big_endian_strap(strap), .addr(addr),
    .data_out(dout), .data_oe(doe), .data_in(din), .byte_strobe_msb_n(s_msb),
    .byte_strobe_hi_n(s_hi), .byte_strobe_lo_n(s_lo),
    .byte_strobe_lsb_n(s_lsb), .out_en_n(oe_n), .rd_wr(rd_wr), .cs_n(cs_n),
    .data_ack_in_n(dack_n), .burst_restart_n(brst_n), .burst_clk(bclk),
    .burst_addr_latch_n(lat_n));
  ebc_mem_model mem_u (.mclk(mclk), .link_clk(link_clk), .cs_n(cs_n),
    .out_en_n(oe_n), .burst_addr_latch_n(lat_n), .data_in(din),
    .data_ack_in_n(dack_n), .burst_restart_n(brst_n), .rd_word(rword),
    .ack_on(ack_on), .restart_on(rs_on));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (expq.size() != 0)
      miscompares++;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  function automatic logic [31:0] sw(input logic [31:0] x, input logic b);
    return b ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
  endfunction
  // Big endian puts the lowest byte address on the most significant lane.
  function automatic logic [3:0] lanes(input logic [3:0] m, input logic b);
    return b ? {m[0], m[1], m[2], m[3]} : m;
  endfunction
  // The strap stays steady from reset onwards.
  task automatic do_reset(input logic s, input int n);
    strap = s;
    rst = 1'b1;
    repeat (n) @(negedge mclk);
    check({req_ready, rsp_valid, cs_n, oe_n, lat_n, bclk},
          {2'b00, 6'h3f, 3'b110});
    rst = 1'b0;
  endtask
  task automatic acc(input logic w, ua, bu, input logic [3:0] be,
                     input logic er);
    ebc_pkg::ebc_req_s r;
    logic [31:0] rd;
    int n;
    r.addr = 25'($urandom);
    r.wdata = $urandom;
    r.be = be;
    r.write = w;
    r.cs = 3'($urandom % 6);
    r.use_ack = ua;
    r.burst = bu;
    rd = $urandom;
    n = 0;
    while (req_ready !== 1'b1 && n < 99) begin
      @(negedge mclk);
      n++;
    end
    if (n == 99)
      miscompares++;
    rword = rd;
    req = r;
    req_valid = 1'b1;
    expq.push_back({!w && !er, er, sw(rd, strap)});
    @(negedge mclk);
    req_valid = 1'b0;
    n = 0;
    while (!bu && cs_n[r.cs] !== 1'b0 && n < 9) begin
      @(negedge mclk);
      n++;
    end
    check(addr, r.addr);
    if (!bu) begin
      check(cs_n, 6'(~(6'h01 << r.cs)));
      check(rd_wr, !w);
      check(oe_n, w);
    end
    if (w) begin
      check({s_msb, s_hi, s_lo, s_lsb}, 4'(~lanes(be, strap)));
      check(dout & doe, sw(r.wdata, strap));
    end
    n = 0;
    while (expq.size() != 0 && n < 999) begin
      @(negedge mclk);
      n++;
    end
    if (n == 999)
      miscompares++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (expq.size() == 0) check(1, 0);
      else begin
        e = expq.pop_front();
        check(rsp.err, e[32]);
        if (e[33]) check(rsp.rdata, e[31:0]);
      end
    end
  end
  always @(negedge lat_n) lats++;
  always @(posedge bclk) bclks++;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {rst, req_valid, fmc, strap, ack_on, rs_on} = 6'h20;
    req = '0;
    sd_n = 2'h2;
    rword = 32'h0;
    void'($urandom(88342));
    do_reset(1'b0, 5);
    repeat (2) @(negedge mclk);
    check(cs_n[3:2], sd_n);
    sd_n = 2'($urandom);
    repeat (3) @(negedge mclk);
    check(cs_n[3:2], sd_n);
    fmc = 1'b1;
    repeat (3) @(negedge mclk);
    check(cs_n[3:2], 2'h3);
    ack_on = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, i[0], 1'b0, 4'($urandom % 15 + 1), 1'b0);
    end
    acc(1'b0, 1'b0, 1'b0, 4'hf, 1'b0);
    acc(1'b0, 1'b1, 1'b0, 4'hf, 1'b0);
    ack_on = 1'b0;
    acc(1'b0, 1'b1, 1'b0, 4'hf, 1'b1);
    lats = 0;
    bclks = 0;
    acc(1'b0, 1'b0, 1'b1, 4'hf, 1'b0);
    check(lats, 1);
    check(bclks > 0, 1);
    rs_on = 1'b1;
    lats = 0;
    acc(1'b0, 1'b0, 1'b1, 4'hf, 1'b0);
    check(lats, 2);
    rs_on = 1'b0;
    do_reset(1'b1, 7);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 1'b0, 1'b0, 4'($urandom % 15 + 1), 1'b0);
    end
    acc(1'b0, 1'b0, 1'b0, 4'hf, 1'b0);
    print_verdict();
  end
endmodule
`default_nettype wire
